// ---- hdl/frame_pkg.sv ----
// Shared constants and carrier types of the command frame handler
package frame_pkg;
    localparam int CORE_BYTES = 7;
    localparam int SERIAL_BYTES = 9;
    localparam int VALUE_BYTES = 4;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_STORED = 8'h65;
    localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    localparam logic [7:0] STATUS_LOCKED = 8'h05;
    localparam logic [7:0] STATUS_NOT_AVAIL = 8'h06;
    localparam logic [7:0] RESET_MODULE_ADDR = 8'h01;
    localparam logic [7:0] RESET_REPLY_ADDR = 8'h02;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] kind;
        logic [7:0] bank;
        logic [31:0] value;
    } command_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] opcode;
        logic [31:0] value;
    } reply_t;
endpackage

// ---- hdl/frame_receiver.sv ----
// Byte collector that assembles and checks one command frame
`timescale 1ns/10ps
module frame_receiver (
    input wire logic clk,
    input wire logic reset,
    input wire logic can_mode,
    input wire logic [7:0] module_addr,
    input wire logic accept,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output frame_pkg::command_t cmd,
    output logic cmd_valid,
    output logic sum_ok
);
    logic [3:0] count;
    logic [3:0] next_count;
    logic [7:0] sum;
    logic [7:0] next_sum;
    logic [7:0] shift [0:6];
    logic drop;
    logic next_drop;
    logic next_cmd_valid;
    logic next_sum_ok;
    logic [3:0] last_index;
    logic [3:0] core_index;

    always_comb begin
        last_index = can_mode ? 4'(frame_pkg::CORE_BYTES - 1) : 4'(frame_pkg::SERIAL_BYTES - 1);
        core_index = can_mode ? count : count - 4'd1;
        next_count = count;
        next_sum = sum;
        next_drop = drop;
        next_cmd_valid = 1'b0;
        next_sum_ok = sum_ok;
        if (rx_valid && accept) begin
            next_sum = sum + rx_data; // [RULE_09]
            if (count == 4'd0) begin
                next_sum = rx_data;
                next_drop = !can_mode && (rx_data != module_addr); // [RULE_17]
            end
            if (count == last_index) begin // [RULE_06]
                next_count = 4'd0;
                next_cmd_valid = !drop;
                next_sum_ok = can_mode || (rx_data == sum); // [RULE_09] [RULE_12]
            end else begin
                next_count = count + 4'd1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= 4'd0;
            sum <= 8'h00;
            drop <= 1'b0;
            cmd_valid <= 1'b0;
            sum_ok <= 1'b0;
        end else begin
            count <= next_count;
            sum <= next_sum;
            drop <= next_drop;
            cmd_valid <= next_cmd_valid;
            sum_ok <= next_sum_ok;
        end
    end

    // Core bytes land in order: opcode, kind, bank, value MSB first [RULE_05] [RULE_07]
    always_ff @(posedge clk) begin
        if (rx_valid && accept && core_index < 4'(frame_pkg::CORE_BYTES)
                && !(count == 4'd0 && !can_mode)) begin
            shift[core_index[2:0]] <= rx_data;
        end
    end

    assign cmd = '{opcode: shift[0], kind: shift[1], bank: shift[2],
                   value: {shift[3], shift[4], shift[5], shift[6]}}; // [RULE_08]
endmodule

// ---- hdl/frame_transmitter.sv ----
// Serialiser that sends one reply frame and drives the line direction
`timescale 1ns/10ps
module frame_transmitter (
    input wire logic clk,
    input wire logic reset,
    input wire logic can_mode,
    input wire logic [7:0] module_addr,
    input wire logic [7:0] reply_addr,
    input wire logic start,
    input wire frame_pkg::reply_t reply,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_enable,
    output logic busy
);
    logic [3:0] index;
    logic [3:0] next_index;
    logic next_busy;
    logic [7:0] sum;
    logic [7:0] next_sum;
    logic [7:0] byte_now;
    logic [3:0] last_index;
    logic [3:0] slot;

    function automatic logic [7:0] reply_byte(input logic [3:0] s, input frame_pkg::reply_t r,
                                              input logic [7:0] ra, input logic [7:0] ma,
                                              input logic [7:0] cs);
        case (s)
            4'd0: reply_byte = ra;
            4'd1: reply_byte = ma;
            4'd2: reply_byte = r.status;
            4'd3: reply_byte = r.opcode;
            4'd4: reply_byte = r.value[31:24];
            4'd5: reply_byte = r.value[23:16];
            4'd6: reply_byte = r.value[15:8];
            4'd7: reply_byte = r.value[7:0];
            default: reply_byte = cs;
        endcase
    endfunction

    always_comb begin
        last_index = can_mode ? 4'(frame_pkg::VALUE_BYTES + 1) : 4'(frame_pkg::SERIAL_BYTES - 1);
        slot = can_mode ? index + 4'd2 : index; // [RULE_13]
        byte_now = reply_byte(slot, reply, reply_addr, module_addr, sum); // [RULE_10] [RULE_08]
        next_index = index;
        next_busy = busy;
        next_sum = sum;
        if (!busy) begin
            if (start) begin
                next_busy = 1'b1; // [RULE_03]
                next_index = 4'd0;
                next_sum = 8'h00;
            end
        end else if (tx_ready) begin
            next_sum = sum + byte_now; // [RULE_11]
            if (index == last_index) begin
                next_busy = 1'b0;
            end else begin
                next_index = index + 4'd1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            index <= 4'd0;
            busy <= 1'b0;
            sum <= 8'h00;
        end else begin
            index <= next_index;
            busy <= next_busy;
            sum <= next_sum;
        end
    end

    assign tx_valid = busy; // [RULE_01]
    assign tx_data = byte_now;
    assign tx_enable = busy; // [RULE_02]
endmodule

// ---- hdl/motion_command_frame_handler.sv ----
// Top of the command frame handler: receive, check, execute, reply
// Function
// [RULE_01] Transmit only when answering a command
// [RULE_02] Transceiver receives except during reply
// [RULE_03] Exactly one reply per processed command
// [RULE_04] Host waits for reply before next command
// [RULE_05] Core: command, type, bank, four value bytes
// [RULE_06] Serial frame adds address and checksum
// [RULE_07] Serial field order address through checksum
// [RULE_08] Value sent most significant byte first
// [RULE_09] Command checksum is 8-bit sum incl. address
// [RULE_10] Reply: reply addr, own addr, status, command, value
// [RULE_11] Reply checksum is 8-bit sum of bytes
// [RULE_12] CAN commands carry no address or checksum
// [RULE_13] CAN replies carry no address or checksum
// [RULE_14] Status 100 executed, 101 stored
// [RULE_15] Error codes 1 to 6 as defined
// [RULE_16] Bad checksum: no execution, error reply
// [RULE_17] Foreign address frames are ignored silently
`timescale 1ns/10ps
module motion_command_frame_handler (
    input wire logic clk,
    input wire logic reset,
    input wire logic can_mode,
    input wire logic [7:0] module_addr,
    input wire logic [7:0] reply_addr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output frame_pkg::command_t exec_cmd,
    output logic exec_valid,
    input wire logic exec_done,
    input wire logic [7:0] exec_status,
    input wire logic [31:0] exec_value,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_enable
);
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        EXEC = 2'b01,
        SEND = 2'b11,
        DRAIN = 2'b10
    } state_t;

    state_t state;
    state_t next_state;
    frame_pkg::command_t cmd;
    logic cmd_valid;
    logic sum_ok;
    frame_pkg::reply_t reply;
    frame_pkg::reply_t next_reply;
    frame_pkg::command_t next_exec_cmd;
    logic next_exec_valid;
    logic next_rx_ready;
    logic start;
    logic next_start;
    logic tx_busy;
    logic tx_valid_raw;
    logic [7:0] tx_data_raw;
    logic tx_enable_raw;

    frame_receiver u_rx (
        .clk(clk),
        .reset(reset),
        .can_mode(can_mode),
        .module_addr(module_addr),
        .accept(rx_ready),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .cmd(cmd),
        .cmd_valid(cmd_valid),
        .sum_ok(sum_ok)
    );

    frame_transmitter u_tx (
        .clk(clk),
        .reset(reset),
        .can_mode(can_mode),
        .module_addr(module_addr),
        .reply_addr(reply_addr),
        .start(start),
        .reply(reply),
        .tx_ready(tx_ready),
        .tx_valid(tx_valid_raw),
        .tx_data(tx_data_raw),
        .tx_enable(tx_enable_raw),
        .busy(tx_busy)
    );

    always_comb begin
        next_state = state;
        next_reply = reply;
        next_exec_cmd = exec_cmd;
        next_exec_valid = 1'b0;
        next_start = 1'b0;
        next_rx_ready = rx_ready;
        case (state)
            IDLE: begin
                if (cmd_valid) begin
                    next_rx_ready = 1'b0; // [RULE_04]
                    next_reply.opcode = cmd.opcode;
                    if (sum_ok) begin
                        next_exec_cmd = cmd;
                        next_exec_valid = 1'b1;
                        next_state = EXEC;
                    end else begin
                        next_reply.status = frame_pkg::STATUS_BAD_SUM; // [RULE_16] [RULE_15]
                        next_reply.value = 32'h0000_0000;
                        next_start = 1'b1;
                        next_state = SEND;
                    end
                end
            end
            EXEC: begin
                if (exec_done) begin
                    next_reply.status = exec_status; // [RULE_14] [RULE_15]
                    next_reply.value = exec_value;
                    next_start = 1'b1; // [RULE_03]
                    next_state = SEND;
                end
            end
            SEND: begin
                if (tx_busy) begin
                    next_state = DRAIN;
                end
            end
            DRAIN: begin
                if (!tx_busy) begin
                    next_rx_ready = 1'b1;
                    next_state = IDLE;
                end
            end
            default: begin
                next_state = IDLE;
                next_rx_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= IDLE;
            reply <= '0;
            exec_cmd <= '0;
            exec_valid <= 1'b0;
            start <= 1'b0;
            rx_ready <= 1'b1;
        end else begin
            state <= next_state;
            reply <= next_reply;
            exec_cmd <= next_exec_cmd;
            exec_valid <= next_exec_valid;
            start <= next_start;
            rx_ready <= next_rx_ready;
        end
    end

    // Registered line outputs; reply only leaves while a reply is in flight
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_enable <= 1'b0;
        end else begin
            tx_valid <= tx_valid_raw; // [RULE_01]
            tx_data <= tx_data_raw;
            tx_enable <= tx_enable_raw; // [RULE_02]
        end
    end
endmodule

// ---- sim/frame_handler_asserts.sv ----
// Port assertions of the command frame handler
`timescale 1ns/10ps
module frame_handler_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic rx_ready,
    input wire logic exec_valid,
    input wire logic exec_done,
    input wire logic tx_valid,
    input wire logic tx_enable,
    input wire logic can_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_tx_in_reply: assert property (tx_valid |-> tx_enable)
        else $error("byte sent outside a reply");
    a_exec_pulse: assert property (exec_valid |=> !exec_valid)
        else $error("execute request longer than one cycle");
    a_reply_after_done: assert property (exec_done |-> ##[1:3] tx_enable)
        else $error("no reply after execution");
    a_exec_blocks_rx: assert property (exec_valid |-> !rx_ready)
        else $error("receiver open while executing");
    a_no_unasked_tx: assert property (rx_ready && !tx_enable |=> !tx_enable)
        else $error("reply started without a command");
    a_reply_length: assert property ($rose(tx_enable) |-> tx_enable [*6])
        else $error("reply shorter than the core");
    a_serial_length: assert property ($rose(tx_enable) && !can_mode |-> tx_enable [*8] ##1 tx_enable ##1 !tx_enable)
        else $error("serial reply not nine bytes long");
    a_no_exec_in_tx: assert property (tx_enable |-> !exec_valid)
        else $error("execute request during reply");
    a_rx_closed_tx: assert property ($rose(tx_enable) |-> !rx_ready)
        else $error("receiver open at reply start");
endmodule
bind motion_command_frame_handler frame_handler_asserts frame_handler_asserts_inst (
    .clk(clk), .reset(reset), .rx_ready(rx_ready), .exec_valid(exec_valid),
    .exec_done(exec_done), .tx_valid(tx_valid), .tx_enable(tx_enable), .can_mode(can_mode));

// ---- sim/link_host.sv ----
// Host master model: sends command bytes, collects reply bytes
`timescale 1ns/10ps
module link_host (
    input wire logic clk,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic tx_ready
);
    logic [7:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'hA5;
        tx_ready = 1'b1;
    end
    always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
    task automatic send_frame(input logic [7:0] fr[$]);
        logic ok;
        foreach (fr[i]) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data = fr[i];
            do begin
                ok = rx_ready;
                @(posedge clk);
            end while (!ok);
            @(negedge clk);
            rx_valid = 1'b0;
            rx_data = ~fr[i];
        end
    endtask
    // Next command only after the whole reply
    task automatic wait_reply(input int n);
        for (int k = 0; k < 80 && got.size() < n; k++) @(negedge clk);
        repeat (6) @(negedge clk);
    endtask
endmodule

// ---- sim/motion_command_frame_handler_test.sv ----
// Self-checking bench of the command frame handler
`timescale 1ns/10ps
module motion_command_frame_handler_test;
    logic clk, reset, can_mode, rx_valid, rx_ready, exec_valid, exec_done;
    logic tx_ready, tx_valid, tx_enable;
    logic [7:0] module_addr, reply_addr, rx_data, exec_status, tx_data;
    logic [31:0] exec_value;
    frame_pkg::command_t exec_cmd;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int execs = 0;
    int en_cycles = 0;
    motion_command_frame_handler motion_command_frame_handler_inst (.clk(clk), .reset(reset),
        .can_mode(can_mode), .module_addr(module_addr), .reply_addr(reply_addr),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .exec_cmd(exec_cmd),
        .exec_valid(exec_valid), .exec_done(exec_done), .exec_status(exec_status),
        .exec_value(exec_value), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_enable(tx_enable));
    link_host link_host_inst (.clk(clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (exec_valid === 1'b1) execs++;
        if (tx_enable === 1'b1) en_cycles++;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
        end
    endtask
    task automatic run(input logic bad, input logic [7:0] addr, input logic [7:0] st,
                       input logic [31:0] v, input frame_pkg::command_t c);
        logic [7:0] fr[$];
        logic [7:0] rep[$];
        logic [7:0] sum;
        logic act;
        int n0;
        int e0;
        act = !bad && (can_mode || addr == module_addr);
        fr = {c.opcode, c.kind, c.bank, c.value[31:24], c.value[23:16], c.value[15:8],
              c.value[7:0]};
        rep = {st, c.opcode, v[31:24], v[23:16], v[15:8], v[7:0]};
        if (!can_mode) begin
            sum = addr;
            foreach (fr[i]) sum += fr[i];
            fr.push_front(addr);
            fr.push_back(sum + {7'h00, bad});
            rep = {reply_addr, module_addr, rep};
            sum = 8'h00;
            foreach (rep[i]) sum += rep[i];
            rep.push_back(sum);
        end
        if (!act && !bad) rep.delete();
        n0 = execs;
        e0 = en_cycles;
        link_host_inst.got.delete();
        link_host_inst.send_frame(fr);
        if (act) begin
            for (int k = 0; k < 10 && exec_valid !== 1'b1; k++) @(negedge clk);
            check(64'(exec_cmd), 64'(c), "command fields");
            exec_status = st;
            exec_value = v;
            exec_done = 1'b1;
            @(negedge clk);
            exec_done = 1'b0;
        end
        link_host_inst.wait_reply(rep.size());
        check(64'(link_host_inst.got.size()), 64'(rep.size()), "reply length");
        foreach (rep[i]) check(64'(link_host_inst.got[i]), 64'(rep[i]), "reply byte");
        check(64'(execs - n0), 64'(act), "execute count");
        check(64'(en_cycles - e0), 64'(rep.size()), "drive cycles");
        check(64'(tx_enable), 64'h0, "line released");
        $display("test done: status %0d", st);
    endtask
    task automatic t_codes;
        logic [7:0] codes[7] = '{frame_pkg::STATUS_OK, frame_pkg::STATUS_STORED,
            frame_pkg::STATUS_BAD_CMD, frame_pkg::STATUS_BAD_TYPE, frame_pkg::STATUS_BAD_VALUE,
            frame_pkg::STATUS_LOCKED, frame_pkg::STATUS_NOT_AVAIL};
        foreach (codes[i]) run(1'b0, module_addr, codes[i], 32'h80FF_01FE + i,
            {8'hF0 + 8'(i), 8'hC3, 8'h7F, 32'hFEDC_BA98 - i});
    endtask
    task automatic t_bad_sum;
        run(1'b1, module_addr, frame_pkg::STATUS_BAD_SUM, 32'h0, {8'h04, 8'h01, 8'h00,
            32'h0007_D000});
    endtask
    task automatic t_foreign;
        run(1'b0, module_addr + 8'h01, 8'h00, 32'h0, {8'h01, 8'h00, 8'h00, 32'h1});
        run(1'b0, module_addr, frame_pkg::STATUS_OK, 32'hFFFF_FFFF, {8'h06, 8'h01, 8'h00,
            32'h0});
    endtask
    task automatic t_can;
        @(negedge clk);
        can_mode = 1'b1;
        run(1'b0, 8'h00, frame_pkg::STATUS_OK, 32'h1234_5678, {8'h02, 8'h00, 8'h01,
            32'h0000_C800});
        can_mode = 1'b0;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        can_mode = 1'b0;
        module_addr = 8'h9C;
        reply_addr = 8'hF2;
        exec_done = 1'b0;
        exec_status = 8'h00;
        exec_value = 32'h0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_codes();
        t_bad_sum();
        t_foreign();
        t_can();
        summarize();
    end
endmodule
